// ===== logic/gdio_pkg.sv
// Package with register map, field positions and reset values of the digital I/O port.
//
// Contract
// - Direction bit one makes the pin an output, zero an input.
// - Input pin with value bit one gets pull-up unless global disable set.
// - Pull-up is off when value bit is zero or pin is output.
// - During reset every pin is high impedance, even without clock; here pins float from the first clock edge in reset.
// - Output pin drives high for value one and low for value zero.
// - Global pull-up disable removes all pull-ups regardless of other bits.
// - Sample bit returns synchronized pin level for any direction.
// - Pin input passes a high-transparent latch then a rising-edge register; here a falling-edge register stands in for the latch.
// - Pin transition reaches sample bit within half to one and half periods.
// - Written pin value reaches sample bit one clock period later.
// - Port has value and direction registers read/write, input register read-only.
// - Single-bit set and clear change only the addressed pin.
// - Deep sleep disables input buffers except wake-up pins.
// - Alternate functions on some pins leave other pins' general I/O unaffected.
// - Global pull-up disable is bit 6 of the control register.
package gdio_pkg;
  localparam int GDIO_PINS = 8;
  localparam logic [2:0] GDIO_ADDR_INPUT = 3'h0;
  localparam logic [2:0] GDIO_ADDR_DIR = 3'h1;
  localparam logic [2:0] GDIO_ADDR_VALUE = 3'h2;
  localparam logic [2:0] GDIO_ADDR_CTRL = 3'h3;
  localparam logic [2:0] GDIO_ADDR_SET = 3'h4;
  localparam logic [2:0] GDIO_ADDR_CLR = 3'h5;
  localparam logic [2:0] GDIO_ADDR_WAKE = 3'h6;
  localparam int GDIO_PULLOFF_BIT = 6;
  localparam int GDIO_SEL_POS = 3;
  localparam int GDIO_IDX_MSB = 2;
  localparam logic [7:0] GDIO_CTRL_MASK = 8'h40;
  localparam logic [7:0] GDIO_RESET_VAL = 8'h00;
  localparam logic [7:0] GDIO_WAKE_RESET = 8'h00;
  localparam logic [7:0] GDIO_ZERO = 8'h00;
  localparam logic [2:0] GDIO_BIT_DIR = 3'h0;
  localparam logic [2:0] GDIO_BIT_VALUE = 3'h1;
endpackage : gdio_pkg

// ===== logic/gdio_sync.sv
// Pin input synchronizer: falling-edge register standing in for a transparent-high latch, followed by a rising-edge register.
`timescale 1ns/100ps
module gdio_sync
  import gdio_pkg::*;
(
  input wire logic clk, // Port clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic clk_en, // Freezes the register while low.
  input wire logic [GDIO_PINS-1:0] pin_in, // Pin levels after the input buffer.
  output logic [GDIO_PINS-1:0] sample // Synchronized pin levels.
);
  logic [GDIO_PINS-1:0] hold_reg;
  logic [GDIO_PINS-1:0] hold_next;
  logic [GDIO_PINS-1:0] sample_reg;
  logic [GDIO_PINS-1:0] sample_next;

  // A latch open while the clock is high shows the rising-edge register the level it held
  // at the falling edge, so the first stage captures on that edge; this avoids a race
  // between latch and register at the same rising edge. Only the register reads it.
  genvar i;
  generate
    for (i = 0; i < GDIO_PINS; i++) begin : g_latch
      assign hold_next[i] = clk_en ? pin_in[i] : hold_reg[i];
    end
  endgenerate

  always_ff @(negedge clk) begin
    hold_reg <= hold_next;
  end

  always_comb begin
    sample_next = sample_reg;
    if (!rst_n) begin
      sample_next = GDIO_RESET_VAL;
    end else if (clk_en) begin
      sample_next = hold_reg;
    end
  end

  always_ff @(posedge clk) begin
    sample_reg <= sample_next;
  end

  assign sample = sample_reg;
endmodule : gdio_sync

// ===== logic/gdio_port.sv
// Eight-pin general digital I/O port with direction, value, sample and pull-up control.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module gdio_port
  import gdio_pkg::*;
(
  input wire logic clk, // Port clock, 100 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low, except read data, which clears to zero.
  input wire logic [2:0] addr, // Register address.
  input wire logic [7:0] wdata, // Write data.
  input wire logic wr_en, // Write strobe.
  input wire logic rd_en, // Read strobe.
  output logic [7:0] rdata, // Read data, valid the cycle after rd_en.
  input wire logic deep_sleep, // Both port and converter clocks stopped.
  input wire logic [GDIO_PINS-1:0] alt_override, // Alternate function owns this pin.
  input wire logic [GDIO_PINS-1:0] alt_oe_n, // Alternate output enable, active low.
  input wire logic [GDIO_PINS-1:0] alt_out, // Alternate output value.
  input wire logic [GDIO_PINS-1:0] pin_i, // Pin level from the pad.
  output logic [GDIO_PINS-1:0] pin_o, // Pin drive value.
  output logic [GDIO_PINS-1:0] pin_oe_n, // Pin output enable, active low.
  output logic [GDIO_PINS-1:0] pullup_en // Pull-up resistor enable per pin.
);
  logic [7:0] dir_reg;
  logic [7:0] dir_next;
  logic [7:0] val_reg;
  logic [7:0] val_next;
  logic pulloff_reg;
  logic pulloff_next;
  logic [7:0] wake_reg;
  logic [7:0] wake_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [GDIO_PINS-1:0] pin_o_reg;
  logic [GDIO_PINS-1:0] pin_o_next;
  logic [GDIO_PINS-1:0] oe_n_reg;
  logic [GDIO_PINS-1:0] oe_n_next;
  logic [GDIO_PINS-1:0] pu_reg;
  logic [GDIO_PINS-1:0] pu_next;
  logic [GDIO_PINS-1:0] buf_in;
  logic [GDIO_PINS-1:0] sample;
  logic [7:0] bit_mask;

  // Input buffer gating: clamped low in deep sleep unless the pin is needed for wake-up.
  genvar i;
  generate
    for (i = 0; i < GDIO_PINS; i++) begin : g_buf
      assign buf_in[i] = pin_i[i] & (~deep_sleep | wake_reg[i]);
    end
  endgenerate

  gdio_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(buf_in),
    .sample(sample)
  );

  // Set and clear use wdata[2:0] as pin index and wdata[3] to select value or direction.
  always_comb begin
    bit_mask = GDIO_ZERO;
    bit_mask[wdata[GDIO_IDX_MSB:0]] = 1'b1;
  end

  // Register file group.
  always_comb begin
    dir_next = dir_reg;
    val_next = val_reg;
    pulloff_next = pulloff_reg;
    wake_next = wake_reg;
    rdata_next = GDIO_ZERO;
    if (!rst_n) begin
      dir_next = GDIO_RESET_VAL;
      val_next = GDIO_RESET_VAL;
      pulloff_next = 1'b0;
      wake_next = GDIO_WAKE_RESET;
    end else if (clk_en) begin
      if (wr_en) begin
        case (addr)
          GDIO_ADDR_DIR: dir_next = wdata;
          GDIO_ADDR_VALUE: val_next = wdata;
          GDIO_ADDR_CTRL: pulloff_next = wdata[GDIO_PULLOFF_BIT];
          GDIO_ADDR_WAKE: wake_next = wdata;
          GDIO_ADDR_SET: begin
            if (wdata[GDIO_SEL_POS] == GDIO_BIT_VALUE[0]) begin
              val_next = val_reg | bit_mask;
            end else begin
              dir_next = dir_reg | bit_mask;
            end
          end
          GDIO_ADDR_CLR: begin
            if (wdata[GDIO_SEL_POS] == GDIO_BIT_VALUE[0]) begin
              val_next = val_reg & ~bit_mask;
            end else begin
              dir_next = dir_reg & ~bit_mask;
            end
          end
          default: begin
          end
        endcase
      end
      if (rd_en) begin
        case (addr)
          GDIO_ADDR_INPUT: rdata_next = sample;
          GDIO_ADDR_DIR: rdata_next = dir_reg;
          GDIO_ADDR_VALUE: rdata_next = val_reg;
          GDIO_ADDR_CTRL: rdata_next = GDIO_CTRL_MASK & {GDIO_PINS{pulloff_reg}};
          GDIO_ADDR_WAKE: rdata_next = wake_reg;
          default: rdata_next = GDIO_ZERO;
        endcase
      end else begin
        rdata_next = GDIO_ZERO;
      end
    end
  end

  always_ff @(posedge clk) begin
    dir_reg <= dir_next;
    val_reg <= val_next;
    pulloff_reg <= pulloff_next;
    wake_reg <= wake_next;
    rdata_reg <= rdata_next;
  end

  // Pin driver group, computed from the next register values so a write shows on the
  // pins at the same edge; the sample then follows one edge later.
  always_comb begin
    pin_o_next = pin_o_reg;
    oe_n_next = oe_n_reg;
    pu_next = pu_reg;
    if (!rst_n) begin
      // Reset is synchronous, so the pins float from the first rising edge that sees it.
      pin_o_next = GDIO_ZERO;
      oe_n_next = ~GDIO_ZERO;
      pu_next = GDIO_ZERO;
    end else if (clk_en) begin
      for (int n = 0; n < GDIO_PINS; n++) begin
        if (alt_override[n]) begin
          oe_n_next[n] = alt_oe_n[n];
          pin_o_next[n] = alt_out[n];
          pu_next[n] = 1'b0;
        end else begin
          oe_n_next[n] = ~dir_next[n];
          pin_o_next[n] = val_next[n];
          pu_next[n] = ~dir_next[n] & val_next[n] & ~pulloff_next;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    pin_o_reg <= pin_o_next;
    oe_n_reg <= oe_n_next;
    pu_reg <= pu_next;
  end

  assign rdata = rdata_reg;
  assign pin_o = pin_o_reg;
  assign pin_oe_n = oe_n_reg;
  assign pullup_en = pu_reg;
endmodule : gdio_port

// ===== tb/gdio_port_monitor.sv
// Checker that ties the pin outputs and read data of the port to its strobes.
`timescale 1ns/100ps
module gdio_port_monitor
  import gdio_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic clk_en, // Run.
  input wire logic [2:0] addr, // Address.
  input wire logic [7:0] wdata, // Write data.
  input wire logic wr_en, // Write.
  input wire logic rd_en, // Read.
  input wire logic [7:0] rdata, // Read data.
  input wire logic deep_sleep, // Sleep.
  input wire logic [7:0] alt_override, // Alternate.
  input wire logic [7:0] pin_i, // Pad.
  input wire logic [7:0] pin_o, // Drive.
  input wire logic [7:0] pin_oe_n, // Enable.
  input wire logic [7:0] pullup_en // Pull-up.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr_ok;
  assign wr_ok = wr_en && clk_en && alt_override == 8'h00;
  a_reset_tristate: assert property (disable iff (1'b0) !rst_n |=> pin_oe_n == 8'hff && pullup_en == 8'h00)
    else $error("pins active in reset");
  a_dir_drive: assert property (wr_ok && addr == GDIO_ADDR_DIR |=> pin_oe_n == ~$past(wdata))
    else $error("direction wrong");
  a_value_drive: assert property (wr_ok && addr == GDIO_ADDR_VALUE |=> ((pin_o ^ $past(wdata)) & ~pin_oe_n) == 8'h00)
    else $error("drive level wrong");
  a_pull_out: assert property (alt_override == 8'h00 |-> (pullup_en & ~pin_oe_n) == 8'h00)
    else $error("pull-up on output");
  a_pulloff_kills: assert property (wr_ok && addr == GDIO_ADDR_CTRL && wdata[GDIO_PULLOFF_BIT] |=> pullup_en == 8'h00)
    else $error("pull-up not disabled");
  a_unmapped_zero: assert property (rd_en && clk_en && addr == 3'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_bit_set: assert property (wr_ok && addr == GDIO_ADDR_SET && !wdata[3] |=>
    pin_oe_n == ($past(pin_oe_n) & ~(8'h01 << $past(wdata[2:0])))) else $error("bit set wrong");
  a_sample_path: assert property ($past(rst_n) && $past(clk_en) && !$past(deep_sleep) && !deep_sleep
    && $stable(pin_i) && rd_en && clk_en && addr == GDIO_ADDR_INPUT |=> rdata == $past(pin_i)) else $error("sample wrong");
  c_pull_off: cover property (wr_ok && addr == GDIO_ADDR_CTRL && wdata[GDIO_PULLOFF_BIT]);
  c_set: cover property (wr_ok && addr == GDIO_ADDR_SET);
  c_sample: cover property (rd_en && addr == GDIO_ADDR_INPUT && !deep_sleep);
endmodule : gdio_port_monitor
bind gdio_port gdio_port_monitor mon_u (.clk, .rst_n, .clk_en, .addr, .wdata, .wr_en, .rd_en, .rdata, .deep_sleep,
  .alt_override, .pin_i, .pin_o, .pin_oe_n, .pullup_en);

// ===== tb/gdio_pads.sv
// Pad model that resolves each pin from the port, an outside driver and the pull-up.
`timescale 1ns/100ps
module gdio_pads
(
  input wire logic [7:0] pin_o, // Port drive.
  input wire logic [7:0] pin_oe_n, // Low drives.
  input wire logic [7:0] pullup_en, // Pull-up.
  input wire logic [7:0] ext_en, // Outside driver on.
  input wire logic [7:0] ext_val, // Outside level.
  output logic [7:0] pin_i // Pad level.
);
  // A floating pad reads the inverse of the drive so a stale level never passes.
  assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en & (pullup_en | ~pin_o));
endmodule : gdio_pads

// ===== tb/general_digital_io_port_test.sv
// Testbench for the digital I/O port.
`timescale 1ns/100ps
module general_digital_io_port_test;
  import gdio_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, deep_sleep = 1'b0, clk_en = 1'b1;
  logic [7:0] alt_override = 8'h00, alt_oe_n = 8'hff, alt_out = 8'h00;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, ext_en = 8'h50, ext_val = 8'h40, rdata, pin_i, pin_o, pin_oe_n, pullup_en;
  int n_fail = 0, compares = 0, cycles = 0;
  always #5 clk = ~clk;
  gdio_port dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .deep_sleep(deep_sleep), .alt_override(alt_override), .alt_oe_n(alt_oe_n),
    .alt_out(alt_out), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en));
  gdio_pads pads_u (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .ext_en(ext_en),
    .ext_val(ext_val), .pin_i(pin_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd
  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(pin_oe_n, 8'hff);
    chk(pullup_en, 8'h00);
    rd(GDIO_ADDR_DIR, 8'h00);
    wr(GDIO_ADDR_VALUE, 8'ha5);
    chk(pullup_en, 8'ha5);
    wr(GDIO_ADDR_DIR, 8'h0f);
    chk(pin_oe_n, 8'hf0);
    chk(pin_o & 8'h0f, 8'h05);
    chk(pullup_en, 8'ha0);
    rd(GDIO_ADDR_INPUT, 8'he5);
    $display("test drive done");
    wr(GDIO_ADDR_CTRL, 8'h40);
    chk(pullup_en, 8'h00);
    rd(GDIO_ADDR_CTRL, 8'h40);
    wr(GDIO_ADDR_CTRL, 8'h00);
    chk(pullup_en, 8'ha0);
    wr(GDIO_ADDR_SET, 8'h04);
    wr(GDIO_ADDR_CLR, 8'h08);
    chk(pin_oe_n, 8'he0);
    wr(GDIO_ADDR_INPUT, 8'hff);
    wr(3'h7, 8'hff);
    rd(GDIO_ADDR_DIR, 8'h1f);
    rd(GDIO_ADDR_VALUE, 8'ha4);
    rd(3'h7, 8'h00);
    $display("test bits done");
    @(posedge clk);
    ext_val <= 8'h00;
    rd(GDIO_ADDR_INPUT, 8'ha4);
    @(posedge clk);
    deep_sleep <= 1'b1;
    rd(GDIO_ADDR_INPUT, 8'h00);
    wr(GDIO_ADDR_WAKE, 8'h80);
    rd(GDIO_ADDR_INPUT, 8'h80);
    $display("test sleep done");
    @(posedge clk);
    rst_n <= 1'b0;
    deep_sleep <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(pin_oe_n, 8'hff);
    chk(pullup_en, 8'h00);
    rd(GDIO_ADDR_DIR, 8'h00);
    rd(GDIO_ADDR_WAKE, 8'h00);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(GDIO_ADDR_DIR, 8'hff);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(GDIO_ADDR_DIR, 8'h00);
    chk(pin_oe_n, 8'hff);
    wr(GDIO_ADDR_DIR, 8'h0f);
    wr(GDIO_ADDR_VALUE, 8'h13);
    @(posedge clk);
    alt_override <= 8'h01;
    alt_oe_n <= 8'hfe;
    alt_out <= 8'h00;
    @(posedge clk);
    #1;
    chk(pin_o & 8'h0f, 8'h02);
    chk(pin_oe_n, 8'hf0);
    chk(pullup_en, 8'h10);
    rd(GDIO_ADDR_VALUE, 8'h13);
    $display("test reset and override done");
    close_out();
  end
endmodule : general_digital_io_port_test
